// File: break_deadtime_output_ctrl.sv
// How it works
// R1: dead time decodes from the 8-bit setting in four ranges of tick multiples.
// R2: dead-time setting ignores writes at lock level one, two or three.
// R3: lock level zero leaves every protectable bit freely writable.
// R4: level one freezes dead time, break enable, polarity, auto enable, idle levels.
// R5: level two also freezes channel polarities and both off-state selects.
// R6: level three also freezes compare mode and compare preload fields.
// R7: lock field takes exactly one write after reset, then is frozen.
// R8: software sets all lockable fields in the first register write.
// R9: idle with enable rising: select zero disables, one drives inactive then idle.
// R10: run with enable rising: select zero disables, one drives polarity inactive level.
// R11: break acts only when enabled; polarity picks its active level.
// R12: a new break polarity is used one bus clock after the write.
// R13: auto enable lets an update event set main output enable without break.
// R14: main output enable zero idles outputs; one drives each enabled output.
// R15: an active break clears main output enable without waiting for a clock.
// R16: tick comes from clock division; dead time delays each active edge.
//
// Added by the designer: register access over APB.
`timescale 1ns/10ps
`default_nettype none
module break_deadtime_output_ctrl (
  // apb clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [bdt_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // timer core side
  input wire logic [bdt_pkg::NCH-1:0] pwm_ref,
  input wire logic update_event,
  output logic [bdt_pkg::NCH*3-1:0] compare_mode,
  output logic [bdt_pkg::NCH-1:0] compare_preload_en,
  // fault pin
  input wire logic break_input,
  // power stage pins
  output logic [bdt_pkg::NCH-1:0] channel_out_true,
  output logic [bdt_pkg::NCH-1:0] channel_out_true_oe,
  output logic [bdt_pkg::NCH-1:0] channel_out_complement,
  output logic [bdt_pkg::NCH-1:0] channel_out_complement_oe,
  output logic main_output_enable
);
  import bdt_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic brk_s1;
    logic brk_s2;
    logic moe;
    logic auto_oe;
    logic brk_en;
    logic brk_pol;
    logic brk_pol_used;
    logic idle_sel;
    logic run_sel;
    logic [7:0] deadtime_setting;
    logic [1:0] lock;
    logic lock_done;
    logic [NCH*2-1:0] idle_lvl;
    logic [NCH*CCEN_STRIDE-1:0] ccen;
    logic [NCH*CCM_STRIDE-1:0] ccm;
    logic [1:0] clk_div;
    logic [1:0] tick_cnt;
    logic [NCH*DT_W-1:0] dt_cnt;
    logic [NCH-1:0] ref_prev;
    logic [NCH-1:0] en_prev;
    logic moe_prev;
    logic [31:0] rdata;
  } state_type;

  state_type st_q;
  state_type st_d;
  logic brk_now;
  logic moe_eff;
  logic wr;
  logic bdt_wr;
  logic tick;
  logic [DT_W-1:0] dt_len;
  logic [NCH-1:0] dt_load;
  logic [NCH-1:0] dt_busy;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] ofs);
    hit = ({a[ADDR_W-1:2], 2'b00} == ofs);
  endfunction

  // R1: dead-time decode
  function automatic logic [DT_W-1:0] dt_ticks(input logic [7:0] s);
    logic [DT_W-1:0] v;
    v = '0;
    if (!s[7]) begin
      v = {2'b00, s};
    end else if (!s[6]) begin
      v = ({4'b0000, s[5:0]} + DT_BASE_64) << 1;
    end else if (!s[5]) begin
      v = ({5'b00000, s[4:0]} + DT_BASE_32) << 3;
    end else begin
      v = ({5'b00000, s[4:0]} + DT_BASE_32) << 4;
    end
    return v;
  endfunction

  // ------------------------------------------------------------
  // async break path
  // ------------------------------------------------------------
  // R11: enable and polarity
  // R15: raw pin gates the enable with no clock in between
  assign brk_now = st_q.brk_en & (break_input == st_q.brk_pol_used);
  assign moe_eff = st_q.moe & ~brk_now;
  assign main_output_enable = moe_eff;

  assign wr = psel & penable & pwrite;
  assign bdt_wr = wr & hit(paddr, OFS_BREAK_DEADTIME_CTRL);
  assign dt_len = dt_ticks(st_q.deadtime_setting);
  // R16: gap starts at edge, else a one-clock overlap slips out
  for (genvar g = 0; g < NCH; g++) begin : g_dead
    assign dt_load[g] = (pwm_ref[g] != st_q.ref_prev[g]) || (moe_eff != st_q.moe_prev) ||
                        ((st_q.ccen[g*CCEN_STRIDE] | st_q.ccen[g*CCEN_STRIDE+2]) &&
                         !st_q.en_prev[g]);
    assign dt_busy[g] = (dt_load[g] && dt_len != '0) || (st_q.dt_cnt[g*DT_W +: DT_W] != '0);
  end
  // R16: tick from clock division
  assign tick = (st_q.clk_div == 2'h0) ||
                (st_q.clk_div == 2'h1 && st_q.tick_cnt[0]) ||
                (st_q.clk_div[1] && st_q.tick_cnt == 2'h3);

  // ------------------------------------------------------------
  // apb slave
  // ------------------------------------------------------------
  // zero wait states; read data captured in the setup cycle
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~(hit(paddr, OFS_CLOCK_CTRL) |
                   hit(paddr, OFS_TIMER_CONTROL_TWO) | hit(paddr, OFS_CHANNEL_MODE_REG) |
                   hit(paddr, OFS_CHANNEL_ENABLE_REG) | hit(paddr, OFS_BREAK_DEADTIME_CTRL));
  assign prdata = st_q.rdata;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.brk_s1 = break_input;
    st_d.brk_s2 = st_q.brk_s1;
    // R12: polarity used one clock late
    st_d.brk_pol_used = st_q.brk_pol;
    st_d.moe_prev = moe_eff;
    st_d.ref_prev = pwm_ref;
    for (int i = 0; i < NCH; i++) begin
      st_d.en_prev[i] = st_q.ccen[i*CCEN_STRIDE] | st_q.ccen[i*CCEN_STRIDE+2];
    end

    if (psel && !penable) begin
      st_d.rdata = 32'h0000_0000;
      if (hit(paddr, OFS_BREAK_DEADTIME_CTRL)) begin
        st_d.rdata[15:0] = {st_q.moe, st_q.auto_oe, st_q.brk_pol, st_q.brk_en,
                            st_q.run_sel, st_q.idle_sel, st_q.lock, st_q.deadtime_setting};
      end else if (hit(paddr, OFS_TIMER_CONTROL_TWO)) begin
        st_d.rdata[NCH*2-1:0] = st_q.idle_lvl;
      end else if (hit(paddr, OFS_CHANNEL_ENABLE_REG)) begin
        st_d.rdata[NCH*CCEN_STRIDE-1:0] = st_q.ccen;
      end else if (hit(paddr, OFS_CHANNEL_MODE_REG)) begin
        st_d.rdata[NCH*CCM_STRIDE-1:0] = st_q.ccm;
      end else if (hit(paddr, OFS_CLOCK_CTRL)) begin
        st_d.rdata[CLK_DIV_LSB+1:CLK_DIV_LSB] = st_q.clk_div;
      end
    end

    if (bdt_wr) begin
      // R3: no protection at level zero
      // R2: dead time frozen from level one
      if (st_q.lock == LOCK_NONE) begin
        st_d.deadtime_setting = pwdata[DTS_LSB+7:DTS_LSB];
        // R4: level one set
        st_d.brk_en = pwdata[BRK_EN_BIT];
        st_d.brk_pol = pwdata[BRK_POL_BIT];
        st_d.auto_oe = pwdata[AUTO_OE_BIT];
      end
      // R5: off-state selects frozen from level two
      if (st_q.lock == LOCK_NONE || st_q.lock == LOCK_ONE) begin
        st_d.idle_sel = pwdata[IDLE_SEL_BIT];
        st_d.run_sel = pwdata[RUN_SEL_BIT];
      end
      // R7: lock field written once
      if (!st_q.lock_done) begin
        st_d.lock = pwdata[LOCK_LSB+1:LOCK_LSB];
        st_d.lock_done = 1'b1;
      end
    end
    if (wr && hit(paddr, OFS_TIMER_CONTROL_TWO) && st_q.lock == LOCK_NONE) begin
      // R4: idle levels frozen from level one
      st_d.idle_lvl = pwdata[NCH*2-1:0];
    end
    if (wr && hit(paddr, OFS_CHANNEL_ENABLE_REG)) begin
      for (int i = 0; i < NCH; i++) begin
        st_d.ccen[i*CCEN_STRIDE] = pwdata[i*CCEN_STRIDE];
        st_d.ccen[i*CCEN_STRIDE+2] = pwdata[i*CCEN_STRIDE+2];
        // R5: polarity bits frozen from level two
        if (st_q.lock == LOCK_NONE || st_q.lock == LOCK_ONE) begin
          st_d.ccen[i*CCEN_STRIDE+1] = pwdata[i*CCEN_STRIDE+1];
          st_d.ccen[i*CCEN_STRIDE+3] = pwdata[i*CCEN_STRIDE+3];
        end
      end
    end
    // R6: compare fields frozen at level three
    if (wr && hit(paddr, OFS_CHANNEL_MODE_REG) && st_q.lock != LOCK_THREE) begin
      st_d.ccm = pwdata[NCH*CCM_STRIDE-1:0];
    end
    if (wr && hit(paddr, OFS_CLOCK_CTRL)) begin
      st_d.clk_div = pwdata[CLK_DIV_LSB+1:CLK_DIV_LSB];
    end

    // R15: synced break also clears the stored bit, so it stays cleared
    if (st_q.brk_en && (st_q.brk_s2 == st_q.brk_pol_used)) begin
      st_d.moe = 1'b0;
    end else if (bdt_wr) begin
      st_d.moe = pwdata[MOE_BIT];
    // R13: re-arm on update event
    end else if (st_q.auto_oe && update_event && !brk_now) begin
      st_d.moe = 1'b1;
    end

    // R16: tick prescaler
    st_d.tick_cnt = tick ? 2'h0 : st_q.tick_cnt + 2'h1;
    for (int i = 0; i < NCH; i++) begin
      // R1: reload on any edge
      if (dt_load[i]) begin
        st_d.dt_cnt[i*DT_W +: DT_W] = dt_len;
      end else if (tick && st_q.dt_cnt[i*DT_W +: DT_W] != '0) begin
        st_d.dt_cnt[i*DT_W +: DT_W] = st_q.dt_cnt[i*DT_W +: DT_W] - 10'h001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ------------------------------------------------------------
  // output stage
  // ------------------------------------------------------------
  // combinational so that a break takes the pins at once
  always_comb begin
    channel_out_true = '0;
    channel_out_true_oe = '0;
    channel_out_complement = '0;
    channel_out_complement_oe = '0;
    for (int i = 0; i < NCH; i++) begin
      if (moe_eff) begin
        // R14: run drives enabled outputs
        // R16: active edges wait out the dead time
        if (st_q.ccen[i*CCEN_STRIDE]) begin
          channel_out_true_oe[i] = 1'b1;
          channel_out_true[i] = (pwm_ref[i] & ~dt_busy[i]) ^
                                st_q.ccen[i*CCEN_STRIDE+1];
        end else if (st_q.run_sel) begin
          // R10: polarity-adjusted inactive level
          channel_out_true_oe[i] = 1'b1;
          channel_out_true[i] = st_q.ccen[i*CCEN_STRIDE+1];
        end
        if (st_q.ccen[i*CCEN_STRIDE+2]) begin
          channel_out_complement_oe[i] = 1'b1;
          channel_out_complement[i] = (~pwm_ref[i] & ~dt_busy[i]) ^
                                      st_q.ccen[i*CCEN_STRIDE+3];
        end else if (st_q.run_sel) begin
          channel_out_complement_oe[i] = 1'b1;
          channel_out_complement[i] = st_q.ccen[i*CCEN_STRIDE+3];
        end
      end else if (st_q.idle_sel) begin
        // R9: inactive through dead time, then idle level
        if (st_q.ccen[i*CCEN_STRIDE]) begin
          channel_out_true_oe[i] = 1'b1;
          channel_out_true[i] = dt_busy[i] ?
                                st_q.ccen[i*CCEN_STRIDE+1] : st_q.idle_lvl[i*2];
        end
        if (st_q.ccen[i*CCEN_STRIDE+2]) begin
          channel_out_complement_oe[i] = 1'b1;
          channel_out_complement[i] = dt_busy[i] ?
                                      st_q.ccen[i*CCEN_STRIDE+3] : st_q.idle_lvl[i*2+1];
        end
      end
    end
  end

  for (genvar g = 0; g < NCH; g++) begin : g_ccm
    assign compare_mode[g*3 +: 3] = st_q.ccm[g*CCM_STRIDE+CCM_MODE_LSB +: 3];
    assign compare_preload_en[g] = st_q.ccm[g*CCM_STRIDE+CCM_PRELOAD_BIT];
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  dt_decode_a: assert property (@(posedge pclk) disable iff (!presetn) // R1
    ($changed(pwm_ref[0])) |=> st_q.dt_cnt[DT_W-1:0] == $past(dt_len))
    else $error("dead time not loaded from decoded setting");
  dts_lock_a: assert property (@(posedge pclk) disable iff (!presetn) // R2
    (bdt_wr && st_q.lock != LOCK_NONE) |=> $stable(st_q.deadtime_setting))
    else $error("dead time changed while locked");
  free_write_a: assert property (@(posedge pclk) disable iff (!presetn) // R3
    (bdt_wr && st_q.lock == LOCK_NONE) |=>
    (st_q.deadtime_setting == $past(pwdata[7:0]) && st_q.brk_en == $past(pwdata[BRK_EN_BIT])))
    else $error("unlocked write not stored");
  level_one_a: assert property (@(posedge pclk) disable iff (!presetn) // R4
    (st_q.lock != LOCK_NONE && wr) |=> $stable({st_q.brk_en, st_q.brk_pol,
    st_q.auto_oe, st_q.idle_lvl}))
    else $error("level one bit changed");
  level_two_a: assert property (@(posedge pclk) disable iff (!presetn) // R5
    (st_q.lock[1] && wr) |=> $stable({st_q.idle_sel, st_q.run_sel,
    st_q.ccen[1], st_q.ccen[3]}))
    else $error("level two bit changed");
  level_three_a: assert property (@(posedge pclk) disable iff (!presetn) // R6
    (st_q.lock == LOCK_THREE && wr) |=> $stable(st_q.ccm))
    else $error("compare fields changed at level three");
  lock_once_a: assert property (@(posedge pclk) disable iff (!presetn) // R7
    (st_q.lock_done && bdt_wr) |=> $stable(st_q.lock))
    else $error("lock field rewritten");
  idle_off_a: assert property (@(posedge pclk) disable iff (!presetn) // R9
    (!moe_eff && !st_q.idle_sel) |-> (channel_out_true_oe == '0 &&
    channel_out_complement_oe == '0))
    else $error("idle outputs driven with select zero");
  run_off_a: assert property (@(posedge pclk) disable iff (!presetn) // R10
    (moe_eff && st_q.run_sel && !st_q.ccen[0]) |->
    (channel_out_true_oe[0] && channel_out_true[0] == st_q.ccen[1]))
    else $error("run off-state level wrong");
  pol_delay_a: assert property (@(posedge pclk) disable iff (!presetn) // R12
    $changed(st_q.brk_pol) |-> (st_q.brk_pol_used != st_q.brk_pol) ##1
    (st_q.brk_pol_used == $past(st_q.brk_pol)))
    else $error("polarity not delayed one clock");
  auto_set_a: assert property (@(posedge pclk) disable iff (!presetn) // R13
    (!st_q.auto_oe && !bdt_wr) |=> !$rose(st_q.moe))
    else $error("output enable set without software");
  break_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // R15
    brk_now |-> !main_output_enable ##3 (!st_q.moe || !st_q.brk_en ||
    $past(bdt_wr) || $past(update_event)))
    else $error("break did not clear output enable");

endmodule // break_deadtime_output_ctrl
`default_nettype wire

// File: bdt_pkg.sv
// ----------------------------------------------------------------
// constants for the break, dead-time and output control block
// ----------------------------------------------------------------
package bdt_pkg;

  // ------------------------------------------------------------
  // sizes
  // ------------------------------------------------------------
  localparam int NCH = 3;
  localparam int ADDR_W = 12;
  localparam int DT_W = 10;

  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [11:0] OFS_CLOCK_CTRL = 12'h000;
  localparam logic [11:0] OFS_TIMER_CONTROL_TWO = 12'h004;
  localparam logic [11:0] OFS_CHANNEL_MODE_REG = 12'h018;
  localparam logic [11:0] OFS_CHANNEL_ENABLE_REG = 12'h020;
  localparam logic [11:0] OFS_BREAK_DEADTIME_CTRL = 12'h044;

  // ------------------------------------------------------------
  // break_deadtime_ctrl field positions
  // ------------------------------------------------------------
  localparam int DTS_LSB = 0;
  localparam int LOCK_LSB = 8;
  localparam int IDLE_SEL_BIT = 10;
  localparam int RUN_SEL_BIT = 11;
  localparam int BRK_EN_BIT = 12;
  localparam int BRK_POL_BIT = 13;
  localparam int AUTO_OE_BIT = 14;
  localparam int MOE_BIT = 15;

  // ------------------------------------------------------------
  // other field positions and widths
  // ------------------------------------------------------------
  localparam int CLK_DIV_LSB = 8;
  localparam int CCEN_STRIDE = 4;
  localparam int CCM_STRIDE = 8;
  localparam int CCM_PRELOAD_BIT = 3;
  localparam int CCM_MODE_LSB = 4;

  // ------------------------------------------------------------
  // reset values and lock levels
  // ------------------------------------------------------------
  localparam logic [15:0] BDT_RESET = 16'h0000;
  localparam logic [1:0] LOCK_NONE = 2'h0;
  localparam logic [1:0] LOCK_ONE = 2'h1;
  localparam logic [1:0] LOCK_TWO = 2'h2;
  localparam logic [1:0] LOCK_THREE = 2'h3;

  // ------------------------------------------------------------
  // dead-time decode bases
  // ------------------------------------------------------------
  localparam logic [DT_W-1:0] DT_BASE_64 = 10'h040;
  localparam logic [DT_W-1:0] DT_BASE_32 = 10'h020;

endpackage

// File: bdt_power_stage.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// gate drivers of the power stage and the fault source
// ----------------------------------------------------------------
module bdt_power_stage (
  // fault level chosen by the bench
  input wire logic fault_level,
  // pins from the block
  input wire logic [bdt_pkg::NCH-1:0] out_true,
  input wire logic [bdt_pkg::NCH-1:0] out_true_oe,
  input wire logic [bdt_pkg::NCH-1:0] out_comp,
  input wire logic [bdt_pkg::NCH-1:0] out_comp_oe,
  // fault pin and gate levels
  output logic break_pin,
  output logic [bdt_pkg::NCH-1:0] gate_true,
  output logic [bdt_pkg::NCH-1:0] gate_comp
);
  import bdt_pkg::*;
  // gate inputs have pull-downs, so a released pin reads low, never the old level
  assign gate_true = out_true & out_true_oe;
  assign gate_comp = out_comp & out_comp_oe;
  // the sensor drives its fault pin as a plain level
  assign break_pin = fault_level;
endmodule // bdt_power_stage
`default_nettype wire

// File: testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import bdt_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [NCH-1:0] pwm_ref = '0;
  logic update_event = 1'b0;
  logic [NCH*3-1:0] compare_mode;
  logic [NCH-1:0] compare_preload_en;
  logic break_level = 1'b1;
  logic break_input;
  logic [NCH-1:0] out_t, out_t_oe, out_c, out_c_oe, gate_true, gate_comp;
  logic main_output_enable;
  logic [31:0] rdat;
  logic err;
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;

  always #4 pclk = ~pclk;

  break_deadtime_output_ctrl DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pwm_ref(pwm_ref), .update_event(update_event),
    .compare_mode(compare_mode), .compare_preload_en(compare_preload_en),
    .break_input(break_input), .channel_out_true(out_t), .channel_out_true_oe(out_t_oe),
    .channel_out_complement(out_c), .channel_out_complement_oe(out_c_oe),
    .main_output_enable(main_output_enable));

  bdt_power_stage stage (.fault_level(break_level), .out_true(out_t), .out_true_oe(out_t_oe),
    .out_comp(out_c), .out_comp_oe(out_c_oe), .break_pin(break_input),
    .gate_true(gate_true), .gate_comp(gate_comp));

  // ----------------------------------------------------------------
  // compare, bus and closing tasks
  // ----------------------------------------------------------------
  task automatic check_reg(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      mismatches++;
    end
  endtask

  task automatic check_pin(input string name, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      $display("wrong value %s expected %b seen %b", name, exp, got);
      mismatches++;
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // one idle edge before each setup, so psel is never driven twice in one step
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] addr, input logic [31:0] wd);
    apb(1'b1, addr, wd);
  endtask

  task automatic rd_check(input logic [11:0] addr, input logic [31:0] exp, input string name);
    apb(1'b0, addr, 32'h0);
    check_reg(name, exp, rdat);
  endtask

  task automatic do_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  // edges from the reference rising to the true gate turning on
  task automatic measure_dt(input logic [7:0] code, input int ticks);
    int n;
    wr(OFS_BREAK_DEADTIME_CTRL, {16'h0, 8'hD8, code});
    @(posedge pclk);
    pwm_ref <= 3'h0;
    repeat (600) @(posedge pclk);
    pwm_ref <= 3'h1;
    n = 0;
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while (gate_true[0] !== 1'b1 && n < 1000);
    check_reg("dead time cycles", 32'(ticks + 1), 32'(n));
  endtask

  // ----------------------------------------------------------------
  // timeout
  // ----------------------------------------------------------------
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      give_verdict;
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd_check(OFS_BREAK_DEADTIME_CTRL, {16'h0, BDT_RESET}, "reset value");
    apb(1'b0, 12'h100, 32'h0);
    check_reg("unmapped data", 32'h0, rdat);
    check_pin("unmapped error", 1'b1, err);
    // first write sets every break and dead-time register field at once, active-low break held idle
    wr(OFS_BREAK_DEADTIME_CTRL, 32'hD802);
    rd_check(OFS_BREAK_DEADTIME_CTRL, 32'hD802, "first write");
    wr(OFS_BREAK_DEADTIME_CTRL, 32'hDB05);
    rd_check(OFS_BREAK_DEADTIME_CTRL, 32'hD805, "second lock write");
    wr(OFS_TIMER_CONTROL_TWO, 32'h3F);
    rd_check(OFS_TIMER_CONTROL_TWO, 32'h3F, "idle levels unlocked");
    check_pin("main enable", 1'b1, main_output_enable);
    wr(OFS_CHANNEL_ENABLE_REG, 32'h1);
    measure_dt(8'h03, 3);
    measure_dt(8'h81, 130);
    measure_dt(8'hC1, 264);
    measure_dt(8'hE1, 528);
    check_pin("true pin driven", 1'b1, out_t_oe[0]);
    @(posedge pclk);
    break_level <= 1'b0;
    #1;
    check_pin("enable at break", 1'b0, main_output_enable);
    check_pin("true pin at break", 1'b0, out_t_oe[0]);
    repeat (4) @(posedge pclk);
    rd_check(OFS_BREAK_DEADTIME_CTRL, 32'h58E1, "stored enable after break");
    @(posedge pclk);
    break_level <= 1'b1;
    repeat (4) @(posedge pclk);
    update_event <= 1'b1;
    @(posedge pclk);
    update_event <= 1'b0;
    #1;
    check_pin("enable on update", 1'b1, main_output_enable);
    wr(OFS_BREAK_DEADTIME_CTRL, 32'hF8E1);
    #1;
    check_pin("old polarity still used", 1'b1, main_output_enable);
    @(posedge pclk);
    #1;
    check_pin("new polarity used", 1'b0, main_output_enable);
    @(posedge pclk);
    break_level <= 1'b0;
    repeat (4) @(posedge pclk);
    wr(OFS_BREAK_DEADTIME_CTRL, 32'hE8E1);
    @(posedge pclk);
    break_level <= 1'b1;
    repeat (4) @(posedge pclk);
    #1;
    check_pin("break disabled", 1'b1, main_output_enable);
    // complement with its own dead time, then idle select one
    wr(OFS_BREAK_DEADTIME_CTRL, 32'hC803);
    wr(OFS_CHANNEL_ENABLE_REG, 32'h5);
    @(posedge pclk);
    pwm_ref <= 3'h0;
    #1;
    check_pin("true off at fall", 1'b0, gate_true[0]);
    check_pin("complement at fall", 1'b0, gate_comp[0]);
    repeat (3) @(posedge pclk);
    #1;
    check_pin("complement in gap", 1'b0, gate_comp[0]);
    @(posedge pclk);
    #1;
    check_pin("complement after gap", 1'b1, out_c[0]);
    wr(OFS_BREAK_DEADTIME_CTRL, 32'h4C03);
    #1;
    check_pin("idle inactive", 1'b0, out_t[0]);
    check_pin("idle driven", 1'b1, out_c_oe[0]);
    repeat (4) @(posedge pclk);
    #1;
    check_pin("idle true level", 1'b1, out_t[0]);
    check_pin("idle complement level", 1'b1, gate_comp[0]);
    for (int lvl = 1; lvl <= 3; lvl++) begin
      do_reset;
      wr(OFS_BREAK_DEADTIME_CTRL, 32'(lvl << 8) | 32'h10);
      wr(OFS_BREAK_DEADTIME_CTRL, 32'hFCAA);
      rd_check(OFS_BREAK_DEADTIME_CTRL, (lvl == 1) ? 32'h8D10 : (32'h8010 | 32'(lvl << 8)),
        "locked control");
      wr(OFS_TIMER_CONTROL_TWO, 32'h3F);
      rd_check(OFS_TIMER_CONTROL_TWO, 32'h0, "locked idle levels");
      wr(OFS_CHANNEL_ENABLE_REG, 32'hFFF);
      rd_check(OFS_CHANNEL_ENABLE_REG, (lvl >= 2) ? 32'h555 : 32'hFFF, "polarities");
      wr(OFS_CHANNEL_MODE_REG, 32'h787878);
      rd_check(OFS_CHANNEL_MODE_REG, (lvl == 3) ? 32'h0 : 32'h787878, "compare modes");
      check_reg("mode pins", (lvl == 3) ? 32'h0 : 32'h1FF, {23'h0, compare_mode});
      check_reg("preload pins", (lvl == 3) ? 32'h0 : 32'h7, {29'h0, compare_preload_en});
    end
    give_verdict;
  end
endmodule // testbench
`default_nettype wire
